// File: hdl/tmps_pkg.sv
// constants and types for the timer0 prescaler and clock select block
package tmps_pkg;
   localparam int          DATA_W          = 8;
   localparam logic [7:0]  MODE_RESET      = 8'h3F;
   localparam int          RATE_LSB        = 0;
   localparam int          RATE_W          = 3;
   localparam int          TO_WDT_BIT      = 3;
   localparam int          EDGE_BIT        = 4;
   localparam int          SRC_BIT         = 5;
   localparam int          SPARE_BIT       = 6;
   localparam int          LOWCLK_BIT      = 7;
   localparam logic [7:0]  COUNT_RESET     = 8'h00;

   typedef struct packed {
      logic       low_clock_select;
      logic       spare_general_bit;
      logic       timer_source_select;
      logic       count_edge_select;
      logic       prescale_to_watchdog;
      logic [2:0] prescale_rate_code;
   } tmps_mode_t;

   typedef struct packed {
      logic timer_tick;
      logic wdt_tick;
   } tmps_tick_t;
endpackage : tmps_pkg

// File: hdl/tmps_edge_sel.sv
// selected-edge detector for the timer clock sources
`timescale 1ns/1ps
module tmps_edge_sel (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // source and control
   input  wire logic src_in,
   input  wire logic falling_sel,
   // result
   output logic      edge_pulse
);
   logic src_reg;
   logic src_next;

   always_comb begin
      src_next = src_in;
   end

   // no reset here: the flop keeps sampling through reset, so a source that
   // sits high when reset is released is not taken for a fresh edge
   always_ff @(posedge clk) begin
      src_reg <= src_next;
   end

   // falling when select high, rising when low; quiet while reset is held
   assign edge_pulse = ~rst
                       & (falling_sel ? (src_reg & ~src_in) : (~src_reg & src_in));
endmodule : tmps_edge_sel

// File: hdl/tmps_top.sv
// timer0 mode register, clock select and shared prescaler
`timescale 1ns/1ps
module tmps_top #(
   parameter int RATE_W = 3
) (
   // clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst,
   // dedicated mode instructions
   input  wire logic                      timer0_mode_write_instr,
   input  wire logic                      timer0_mode_read_instr,
   input  wire logic [7:0]                instr_wdata,
   output logic      [7:0]                mode_rdata,
   // prescale count value read
   input  wire logic                      count_read,
   output logic      [7:0]                prescale_count_value,
   // clock sources
   input  wire logic                      instruction_clock,
   input  wire logic                      ext_count_clock_pin,
   input  wire logic                      internal_low_rc,
   input  wire logic                      external_low_crystal,
   input  wire logic                      cfg_low_osc_crystal,
   // watchdog side
   input  wire logic                      wdt_base_tick,
   input  wire logic                      wdt_interrupt_mode,
   // results
   output tmps_pkg::tmps_tick_t           ticks,
   output tmps_pkg::tmps_mode_t           mode
);
   tmps_pkg::tmps_mode_t mode_reg;
   tmps_pkg::tmps_mode_t mode_next;
   logic [7:0]           rdata_reg;
   logic [7:0]           rdata_next;
   logic [7:0]           cnt_reg;
   logic [7:0]           cnt_next;
   logic [7:0]           cvr_reg;
   logic [7:0]           cvr_next;
   logic                 tmr_reg;
   logic                 tmr_next;
   logic                 wdt_reg;
   logic                 wdt_next;
   logic                 low_osc;
   logic                 ext_src;
   logic                 ext_edge;
   logic                 src_tick;
   logic                 pre_in;
   logic [8:0]           div_len;
   logic [8:0]           cnt_w;
   logic                 full_group;
   logic                 bypass;

   // mode register: only the two dedicated instructions touch it
   always_comb begin
      mode_next  = mode_reg;
      rdata_next = rdata_reg;
      if (timer0_mode_write_instr) begin
         mode_next = tmps_pkg::tmps_mode_t'(instr_wdata);
      end
      if (timer0_mode_read_instr) begin
         rdata_next = mode_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg  <= tmps_pkg::tmps_mode_t'(tmps_pkg::MODE_RESET);
         rdata_reg <= 8'h00;
      end else begin
         mode_reg  <= mode_next;
         rdata_reg <= rdata_next;
      end
   end

   assign mode       = mode_reg;
   assign mode_rdata = rdata_reg;

   // clock source selection
   assign low_osc = cfg_low_osc_crystal ? external_low_crystal : internal_low_rc;
   assign ext_src = mode_reg.low_clock_select ? low_osc : ext_count_clock_pin;

   tmps_edge_sel u_edge (
      .clk         (clk),
      .rst         (rst),
      .src_in      (ext_src),
      .falling_sel (mode_reg.count_edge_select),
      .edge_pulse  (ext_edge)
   );

   assign src_tick = mode_reg.timer_source_select ? ext_edge : instruction_clock;

   // shared prescaler input and length
   assign pre_in = mode_reg.prescale_to_watchdog ? wdt_base_tick : src_tick;
   assign bypass = mode_reg.prescale_to_watchdog & ~wdt_interrupt_mode
                   & (mode_reg.prescale_rate_code == 3'h0);

   always_comb begin
      if (mode_reg.prescale_to_watchdog && !wdt_interrupt_mode) begin
         div_len = 9'h001 << mode_reg.prescale_rate_code;
      end else begin
         div_len = 9'h002 << mode_reg.prescale_rate_code;
      end
   end

   assign cnt_w      = {1'b0, cnt_reg};
   assign full_group = pre_in & ((cnt_w + 9'h001) >= div_len);

   always_comb begin
      cnt_next = cnt_reg;
      tmr_next = 1'b0;
      wdt_next = 1'b0;
      cvr_next = cvr_reg;
      if (pre_in) begin
         if (full_group || bypass) begin
            cnt_next = 8'h00;
            tmr_next = ~mode_reg.prescale_to_watchdog;
            wdt_next = mode_reg.prescale_to_watchdog;
         end else begin
            cnt_next = cnt_reg + 8'h01;
         end
      end
      if (count_read) begin
         cvr_next = cnt_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_reg <= tmps_pkg::COUNT_RESET;
         cvr_reg <= 8'h00;
         tmr_reg <= 1'b0;
         wdt_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         cvr_reg <= cvr_next;
         tmr_reg <= tmr_next;
         wdt_reg <= wdt_next;
      end
   end

   assign prescale_count_value = cvr_reg;
   assign ticks.timer_tick     = tmr_reg;
   assign ticks.wdt_tick       = wdt_reg;

   // register access checks
   write_takes_a: assert property (@(posedge clk) disable iff (rst)
      timer0_mode_write_instr |=> mode_reg == $past(instr_wdata))
      else $error("mode write not stored");
   read_returns_a: assert property (@(posedge clk) disable iff (rst)
      timer0_mode_read_instr |=> mode_rdata == $past(mode_reg))
      else $error("mode read wrong");
   mode_hold_a: assert property (@(posedge clk) disable iff (rst)
      !timer0_mode_write_instr |=> mode_reg == $past(mode_reg))
      else $error("mode changed without a write");
   rdata_hold_a: assert property (@(posedge clk) disable iff (rst)
      !timer0_mode_read_instr |=> mode_rdata == $past(mode_rdata))
      else $error("read data changed without a read");
   reset_state_a: assert property (@(posedge clk)
      (rst && $past(rst)) |-> (mode_reg == tmps_pkg::MODE_RESET && mode_rdata == 8'h00
                               && cnt_reg == tmps_pkg::COUNT_RESET && ticks == 2'b00))
      else $error("reset state wrong");
   count_read_a: assert property (@(posedge clk) disable iff (rst)
      count_read |=> prescale_count_value == $past(cnt_reg))
      else $error("count read not live");
   count_hold_a: assert property (@(posedge clk) disable iff (rst)
      !count_read |=> prescale_count_value == $past(prescale_count_value))
      else $error("count value changed without a read");

   // prescaler checks
   timer_route_a: assert property (@(posedge clk) disable iff (rst)
      ticks.timer_tick |-> !$past(mode_reg.prescale_to_watchdog))
      else $error("timer tick while on watchdog");
   wdt_route_a: assert property (@(posedge clk) disable iff (rst)
      ticks.wdt_tick |-> $past(mode_reg.prescale_to_watchdog))
      else $error("watchdog tick while on timer");
   timer_div_a: assert property (@(posedge clk) disable iff (rst)
      (!timer0_mode_write_instr && !mode_reg.prescale_to_watchdog
       && mode_reg.prescale_rate_code == 3'h0 && pre_in && cnt_reg == 8'h01)
      |=> ticks.timer_tick)
      else $error("divide by two missed");
   timer_gap_a: assert property (@(posedge clk) disable iff (rst)
      ticks.timer_tick |=> !ticks.timer_tick)
      else $error("timer ticks back to back");
   wdt_bypass_a: assert property (@(posedge clk) disable iff (rst)
      (pre_in && bypass) |=> ticks.wdt_tick)
      else $error("one to one watchdog missed");
   idle_count_a: assert property (@(posedge clk) disable iff (rst)
      !pre_in |=> cnt_reg == $past(cnt_reg))
      else $error("prescaler moved without an input pulse");
   inst_count_a: assert property (@(posedge clk) disable iff (rst)
      (!mode_reg.timer_source_select && !mode_reg.prescale_to_watchdog
       && instruction_clock && !full_group) |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("instruction clock not counted");
   count_bound_a: assert property (@(posedge clk) disable iff (rst)
      !timer0_mode_write_instr
      |=> cnt_w < $past(div_len) || $past(cnt_w) >= $past(div_len))
      else $error("prescaler overran its group");

   // clock source checks
   ext_rise_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg.timer_source_select && !mode_reg.count_edge_select && $rose(ext_src))
      |-> src_tick)
      else $error("rising edge not counted");
   ext_fall_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg.timer_source_select && mode_reg.count_edge_select && $fell(ext_src))
      |-> src_tick)
      else $error("falling edge not counted");
   rc_rise_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg.timer_source_select && mode_reg.low_clock_select
       && !mode_reg.count_edge_select && !cfg_low_osc_crystal && $stable(mode_reg)
       && $stable(cfg_low_osc_crystal) && $rose(internal_low_rc)) |-> src_tick)
      else $error("low rc edge not counted");
   xtal_fall_a: assert property (@(posedge clk) disable iff (rst)
      (mode_reg.timer_source_select && mode_reg.low_clock_select
       && mode_reg.count_edge_select && cfg_low_osc_crystal && $stable(mode_reg)
       && $stable(cfg_low_osc_crystal) && $fell(external_low_crystal)) |-> src_tick)
      else $error("low crystal edge not counted");

   // scenario covers
   timer_tick_c: cover property (@(posedge clk) disable iff (rst) ticks.timer_tick);
   wdt_tick_c: cover property (@(posedge clk) disable iff (rst) ticks.wdt_tick);
   low_osc_c: cover property (@(posedge clk) disable iff (rst)
      mode_reg.low_clock_select && mode_reg.timer_source_select && ext_edge);
   wdt_bypass_c: cover property (@(posedge clk) disable iff (rst) pre_in && bypass);
   count_read_c: cover property (@(posedge clk) disable iff (rst)
      count_read && cnt_reg != 8'h00);
endmodule : tmps_top

// File: test/tmps_src_model.sv
// model of the external count pin and the two low-frequency oscillators
`timescale 1ns/1ps
module tmps_src_model (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // control from the bench
   input  wire logic       run,
   input  wire logic [1:0] sel,
   // source levels
   output logic            ext_pin,
   output logic            low_rc,
   output logic            low_xtal
);
   logic lvl_reg;
   // toggles once per cycle while run is high, otherwise holds its level
   always_ff @(posedge clk or posedge rst) begin
      if (rst) lvl_reg <= 1'b0;
      else if (run) lvl_reg <= ~lvl_reg;
   end
   // only the chosen source moves; the others stay low
   assign ext_pin  = (sel == 2'h0) ? lvl_reg : 1'b0;
   assign low_rc   = (sel == 2'h1) ? lvl_reg : 1'b0;
   assign low_xtal = (sel == 2'h2) ? lvl_reg : 1'b0;
endmodule : tmps_src_model

// File: test/test_timer0_prescaler_clock_select.sv
// self-checking bench for the timer0 mode register and prescaler
`timescale 1ns/1ps
module test_timer0_prescaler_clock_select;
   logic                 clk = 1'b0, rst = 1'b1, wr_i = 1'b0, rd_i = 1'b0, cnt_rd = 1'b0;
   logic                 inst_clk = 1'b0, cfg = 1'b0, wdt_b = 1'b0, wdt_im = 1'b0, run = 1'b0;
   logic [7:0]           wdata = 8'h00;
   logic [1:0]           sel = 2'h0;
   logic [7:0]           rdata, cval;
   logic                 pin, lrc, lxt;
   tmps_pkg::tmps_tick_t ticks;
   tmps_pkg::tmps_mode_t mode;
   int                   n_mismatch = 0, cmp_count = 0;

   always #20 clk = ~clk;

   tmps_top tmps_top_inst (.clk(clk), .rst(rst), .timer0_mode_write_instr(wr_i),
      .timer0_mode_read_instr(rd_i), .instr_wdata(wdata), .mode_rdata(rdata),
      .count_read(cnt_rd), .prescale_count_value(cval), .instruction_clock(inst_clk),
      .ext_count_clock_pin(pin), .internal_low_rc(lrc), .external_low_crystal(lxt),
      .cfg_low_osc_crystal(cfg), .wdt_base_tick(wdt_b), .wdt_interrupt_mode(wdt_im),
      .ticks(ticks), .mode(mode));
   tmps_src_model tmps_src_model_inst (.clk(clk), .rst(rst), .run(run), .sel(sel),
      .ext_pin(pin), .low_rc(lrc), .low_xtal(lxt));

   task automatic complete_run;
      if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic do_reset;
      rst <= 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   task automatic wr(input logic [7:0] d);
      @(posedge clk);
      wr_i  <= 1'b1;
      wdata <= d;
      @(posedge clk);
      wr_i  <= 1'b0;
   endtask : wr

   task automatic rd;
      @(posedge clk);
      rd_i <= 1'b1;
      @(posedge clk);
      rd_i <= 1'b0;
      #1;
   endtask : rd

   // interval in cycles between two ticks; the other tick must stay quiet
   task automatic measure(input bit w, input int exp);
      int n;
      int k;
      n = 0;
      k = 0;
      #1;
      while ((w ? ticks.wdt_tick : ticks.timer_tick) !== 1'b1 && n < 600) begin
         @(posedge clk);
         #1;
         n++;
      end
      do begin
         @(posedge clk);
         #1;
         k++;
         if ((w ? ticks.timer_tick : ticks.wdt_tick) !== 1'b0) chk(16'h1, 16'h0);
      end while ((w ? ticks.wdt_tick : ticks.timer_tick) !== 1'b1 && k < 600);
      if (n >= 600 || k >= 600) begin
         n_mismatch++;
         complete_run();
      end
      chk(16'(k), 16'(exp));
   endtask : measure

   task automatic reg_access;
      #1;
      chk(16'(mode), 16'h3F);
      rd();
      chk(16'(rdata), 16'h3F);
      wr(8'h55);
      wr(8'hAA);
      rd();
      chk(16'(rdata), 16'hAA);
   endtask : reg_access

   task automatic rate_scan;
      @(posedge clk);
      inst_clk <= 1'b1;
      wdt_b    <= 1'b1;
      for (int n = 0; n < 8; n++) begin
         wr(8'(n));
         measure(1'b0, 2 << n);
      end
      for (int m = 0; m < 2; m++) begin
         @(posedge clk);
         wdt_im <= 1'(m);
         for (int n = 0; n < 8; n++) begin
            wr(8'h08 | 8'(n));
            measure(1'b1, (m == 1) ? (2 << n) : (1 << n));
         end
      end
      @(posedge clk);
      wdt_b <= 1'b0;
   endtask : rate_scan

   // three source toggles give two rising edges and one falling edge
   task automatic edge_scan;
      for (int s = 0; s < 3; s++) begin
         for (int e = 0; e < 2; e++) begin
            @(posedge clk);
            do_reset();
            sel <= 2'(s);
            cfg <= (s == 2);
            wr(8'h27 | ((s != 0) ? 8'h80 : 8'h00) | ((e != 0) ? 8'h10 : 8'h00));
            run <= 1'b1;
            repeat (3) @(posedge clk);
            run <= 1'b0;
            repeat (4) @(posedge clk);
            cnt_rd <= 1'b1;
            @(posedge clk);
            cnt_rd <= 1'b0;
            #1;
            chk(16'(cval), (e != 0) ? 16'h1 : 16'h2);
         end
      end
   endtask : edge_scan

   initial begin
      #(40 * 20000);
      n_mismatch++;
      complete_run();
   end

   initial begin
      do_reset();
      reg_access();
      rate_scan();
      edge_scan();
      complete_run();
   end
endmodule : test_timer0_prescaler_clock_select
